// ### src/usf_pkg.sv
// usf_pkg: offsets, field positions, reset values and state type of the
// serial mode and flag block; assumes a 32-bit Avalon-MM register slave.
package usf_pkg;

   // byte offsets
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_DATA = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_GUARD = 5'h0C;
   localparam logic [4:0] OFS_PEND = 5'h10;

   // status word bit positions
   localparam int SB_PE = 0;
   localparam int SB_FE = 1;
   localparam int SB_NE = 2;
   localparam int SB_ORE = 3;
   localparam int SB_IDLE = 4;
   localparam int SB_RX_HOLDING_FULL = 5;
   localparam int SB_TC = 6;
   localparam int SB_TXE = 7;
   localparam int SB_LBD = 8;
   localparam int SB_CTS = 9;
   localparam logic [9:0] ST_W0C = 10'h360;
   localparam logic [9:0] ST_SEQ_CLR = 10'h01F;
   localparam logic [9:0] ST_RST = 10'h0C0;

   // control word bit positions
   localparam int CB_LIN = 0;
   localparam int CB_BRK11 = 1;
   localparam int CB_SBRK = 2;
   localparam int CB_HDX = 3;
   localparam int CB_SC = 4;
   localparam int CB_NACK = 5;
   localparam int CB_IRDA = 6;
   localparam int CB_IRLP = 7;
   localparam int CB_DMAT = 8;
   localparam int CB_DMAR = 9;
   localparam int CB_IE_CTS = 10;
   localparam int CB_IE_LBD = 11;
   localparam int CB_IE_TXE = 12;
   localparam int CB_IE_TC = 13;
   localparam int CB_IE_RX_HOLDING_FULL = 14;
   localparam int CB_IE_IDLE = 15;
   localparam int CB_IE_PE = 16;
   localparam int CB_IE_ERR = 17;
   localparam logic [17:0] CTRL_SC_BITS = 18'h0_0030;
   localparam logic [17:0] CTRL_RST = 18'h0_0000;

   // counts in bit times
   localparam logic [3:0] BRK_DET_10 = 4'hA;
   localparam logic [3:0] BRK_DET_11 = 4'hB;
   localparam logic [3:0] BRK_TX_BITS = 4'hD;

   typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_GUARD, TX_BREAK} usf_tx_t;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [9:0] st;
      logic [17:0] ctl;
      logic [7:0] guard;
      logic [8:0] dr_rx;
      logic [8:0] dr_tx;
      logic hold_full;
      logic sr_seen;
      logic [2:0] rx_sync;
      logic rx_f;
      logic [2:0] cts_sync;
      logic cts_f;
      logic [3:0] low_cnt;
      logic brk_seen;
      usf_tx_t txs;
      logic [7:0] cnt;
      logic nack_act;
      logic tx_load;
      logic [8:0] tx_data;
      logic tx_o;
   } usf_state_t;

endpackage : usf_pkg

// ### src/usf_top.sv
// usf_top: status flags, clearing sequences, LIN break, half duplex,
// smartcard guard and NACK, IrDA and DMA controls behind an Avalon-MM slave.
// assumes an external baud tick, character receiver and shift transmitter
// on mclk.
//
// The Avalon-MM interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module usf_top #(
   parameter bit HAS_SYNC = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // serial pins
   input wire logic rx_i,
   input wire logic tx_i,
   output logic tx_o,
   output logic tx_oe,
   input wire logic cts_n,
   // baud tick
   input wire logic bit_tick,
   // character receiver
   output logic rx_line,
   input wire logic rx_valid,
   input wire logic [8:0] rx_data,
   input wire logic rx_parity_err,
   input wire logic rx_frame_err,
   input wire logic rx_noise_err,
   input wire logic rx_idle,
   // shift transmitter
   output logic tx_load,
   output logic [8:0] tx_data,
   input wire logic tx_serial,
   input wire logic tx_done,
   // mode outputs
   output logic irda_enable,
   output logic irda_low_power,
   output logic dma_transmit_request,
   output logic dma_receive_request
);
   import usf_pkg::*;

   usf_state_t q;
   usf_state_t n;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////
   // bus decode and derived terms

   logic req;
   logic acc;
   logic rd_acc;
   logic wr_acc;
   logic [31:0] bm;
   logic [9:0] pend;
   logic [17:0] ctl_w;
   logic [3:0] brk_thr;
   logic sc_on;
   logic sel_status;
   logic sel_data;
   logic [31:0] mrg;

   assign req = read | write;
   assign waitrequest = req & ~q.ack;
   assign acc = req & q.ack;
   assign rd_acc = acc & read;
   assign wr_acc = acc & write;
   assign bm = lane_mask(byteenable);
   assign sel_status = (address == OFS_STATUS);
   assign sel_data = (address == OFS_DATA);
   // smartcard features exist only with synchronous support
   assign sc_on = HAS_SYNC & q.ctl[CB_SC];
   assign brk_thr = q.ctl[CB_BRK11] ? BRK_DET_11 : BRK_DET_10;

   // pending per source, overrun, noise and framing errors under one enable
   always_comb begin
      pend = '0;
      pend[SB_CTS] = q.st[SB_CTS] & q.ctl[CB_IE_CTS];
      pend[SB_LBD] = q.st[SB_LBD] & q.ctl[CB_IE_LBD];
      pend[SB_TXE] = q.st[SB_TXE] & q.ctl[CB_IE_TXE];
      pend[SB_TC] = q.st[SB_TC] & q.ctl[CB_IE_TC];
      pend[SB_RX_HOLDING_FULL] = q.st[SB_RX_HOLDING_FULL] & q.ctl[CB_IE_RX_HOLDING_FULL];
      pend[SB_IDLE] = q.st[SB_IDLE] & q.ctl[CB_IE_IDLE];
      pend[SB_PE] = q.st[SB_PE] & q.ctl[CB_IE_PE];
      pend[SB_ORE] = q.st[SB_ORE] & q.ctl[CB_IE_ERR];
      pend[SB_NE] = q.st[SB_NE] & q.ctl[CB_IE_ERR];
      pend[SB_FE] = q.st[SB_FE] & q.ctl[CB_IE_ERR];
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic [9:0] st_set;
   logic [9:0] st_clr;

   always_comb begin
      n = q;
      st_set = '0;
      st_clr = '0;
      ctl_w = q.ctl;
      mrg = '0;
      n.tx_load = 1'b0;

      // bus handshake: request taken one edge after it appears
      n.ack = req & ~q.ack;
      if (req & ~q.ack) begin
         // refreshed on writes too; only a read hands it over
         case (address)
            OFS_STATUS: n.rdata = {22'h00_0000, q.st};
            OFS_DATA: n.rdata = {23'h00_0000, q.dr_rx};
            OFS_CTRL: n.rdata = {14'h0000, q.ctl};
            OFS_GUARD: n.rdata = {24'h00_0000, q.guard};
            OFS_PEND: n.rdata = {22'h00_0000, pend};
            default: n.rdata = 32'h0000_0000;
         endcase
      end

      // pin synchronisers; a change counts once stages two and three agree
      n.rx_sync = {q.rx_sync[1:0], q.ctl[CB_HDX] ? tx_i : rx_i};
      if (q.rx_sync[2] == q.rx_sync[1]) begin
         n.rx_f = q.rx_sync[2];
      end
      // with synchronous support, any settled change of clear-to-send raises its flag
      n.cts_sync = {q.cts_sync[1:0], cts_n};
      if (q.cts_sync[2] == q.cts_sync[1]) begin
         n.cts_f = q.cts_sync[2];
         if (HAS_SYNC && q.cts_sync[2] != q.cts_f) begin
            st_set[SB_CTS] = 1'b1;
         end
      end

      // register accesses and their side effects
      // a status read arms the clearing sequence; any data access ends it
      if (rd_acc && sel_status) begin
         n.sr_seen = 1'b1;
      end
      // data read clears receive full; a status read first also clears errors
      if (rd_acc && sel_data) begin
         st_clr[SB_RX_HOLDING_FULL] = 1'b1;
         if (q.sr_seen) begin
            st_clr = st_clr | ST_SEQ_CLR;
         end
         n.sr_seen = 1'b0;
      end
      if (wr_acc) begin
         case (address)
            OFS_STATUS: begin
               st_clr = st_clr | (ST_W0C & bm[9:0] & ~writedata[9:0]);
            end
            OFS_DATA: begin
               // the data word takes bits 8:0 whatever the lanes
               n.dr_tx = writedata[8:0];
               n.hold_full = 1'b1;
               st_clr[SB_TXE] = 1'b1;
               if (q.sr_seen) begin
                  st_clr[SB_TC] = 1'b1;
               end
               n.sr_seen = 1'b0;
            end
            OFS_CTRL: begin
               mrg = merge({14'h0000, q.ctl}, writedata, bm);
               ctl_w = mrg[17:0];
               if (!HAS_SYNC) begin
                  ctl_w = ctl_w & ~CTRL_SC_BITS;
               end
            end
            OFS_GUARD: begin
               if (HAS_SYNC) begin
                  mrg = merge({24'h00_0000, q.guard}, writedata, bm);
                  n.guard = mrg[7:0];
               end
            end
            default: ;
         endcase
      end

      // receive side
      if (rx_valid) begin
         // overrun keeps the stored character and its flags
         if (q.st[SB_RX_HOLDING_FULL]) begin
            st_set[SB_ORE] = 1'b1;
         end else begin
            n.dr_rx = rx_data;
            st_set[SB_RX_HOLDING_FULL] = 1'b1;
            st_set[SB_PE] = rx_parity_err;
            st_set[SB_FE] = rx_frame_err;
            st_set[SB_NE] = rx_noise_err;
         end
         // the nack holds the line low until the next bit time
         if (rx_parity_err && sc_on && q.ctl[CB_NACK]) begin
            n.nack_act = 1'b1;
         end
      end else if (q.nack_act && bit_tick) begin
         n.nack_act = 1'b0;
      end
      st_set[SB_IDLE] = rx_idle;

      // LIN break detection on the filtered line
      // one flag per low stretch; the line must rise before the next
      if (!q.ctl[CB_LIN] || q.rx_f) begin
         n.low_cnt = '0;
         n.brk_seen = 1'b0;
      end else if (bit_tick && !q.brk_seen) begin
         n.low_cnt = q.low_cnt + 4'h1;
         if (q.low_cnt + 4'h1 == brk_thr) begin
            st_set[SB_LBD] = 1'b1;
            n.brk_seen = 1'b1;
         end
      end

      // transmit sequencer
      // a break request goes ahead of a waiting character
      case (q.txs)
         TX_IDLE: begin
            if (q.ctl[CB_SBRK]) begin
               n.txs = TX_BREAK;
               n.cnt = '0;
            end else if (q.hold_full) begin
               n.tx_load = 1'b1;
               n.tx_data = q.dr_tx;
               n.hold_full = 1'b0;
               st_set[SB_TXE] = 1'b1;
               n.txs = TX_BUSY;
            end
         end
         // complete only with nothing left in the holding register
         TX_BUSY: begin
            if (tx_done) begin
               n.cnt = '0;
               if (sc_on && q.guard != 8'h00) begin
                  n.txs = TX_GUARD;
               end else begin
                  n.txs = TX_IDLE;
                  st_set[SB_TC] = ~n.hold_full;
               end
            end
         end
         // guard bit times count from the end of the frame
         TX_GUARD: begin
            if (bit_tick) begin
               n.cnt = q.cnt + 8'h01;
               if (q.cnt + 8'h01 == q.guard) begin
                  n.txs = TX_IDLE;
                  st_set[SB_TC] = ~n.hold_full;
               end
            end
         end
         TX_BREAK: begin
            if (bit_tick) begin
               n.cnt = q.cnt + 8'h01;
               if (q.cnt + 8'h01 == {4'h0, BRK_TX_BITS}) begin
                  n.txs = TX_IDLE;
                  ctl_w[CB_SBRK] = 1'b0;
                  st_set[SB_TC] = ~n.hold_full;
               end
            end
         end
         default: n.txs = TX_IDLE;
      endcase

      // line drive: break and NACK pull low over the shifter bit
      n.tx_o = tx_serial & (q.txs != TX_BREAK) & ~q.nack_act;

      n.ctl = ctl_w;
      // hardware set wins over any clear in the same edge
      n.st = (q.st & ~st_clr) | st_set;
      if (!HAS_SYNC) begin
         n.st[SB_CTS] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= '{
            ack: 1'b0,
            rdata: 32'h0000_0000,
            st: ST_RST,
            ctl: CTRL_RST,
            guard: 8'h00,
            dr_rx: 9'h000,
            dr_tx: 9'h000,
            hold_full: 1'b0,
            sr_seen: 1'b0,
            rx_sync: 3'h7,
            rx_f: 1'b1,
            cts_sync: 3'h7,
            cts_f: 1'b1,
            low_cnt: 4'h0,
            brk_seen: 1'b0,
            txs: TX_IDLE,
            cnt: 8'h00,
            nack_act: 1'b0,
            tx_load: 1'b0,
            tx_data: 9'h000,
            tx_o: 1'b1
         };
      end else begin
         q <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign readdata = q.rdata;
   assign rx_line = q.rx_f;
   assign tx_load = q.tx_load;
   assign tx_data = q.tx_data;
   assign tx_o = q.tx_o;
   // half duplex releases the shared line unless something is being sent
   assign tx_oe = ~q.ctl[CB_HDX] | (q.txs != TX_IDLE) | q.nack_act;
   assign irda_enable = q.ctl[CB_IRDA];
   assign irda_low_power = q.ctl[CB_IRLP];
   // dma requests follow the flags, so a data access drops them at once
   assign dma_transmit_request = q.ctl[CB_DMAT] & q.st[SB_TXE];
   assign dma_receive_request = q.ctl[CB_DMAR] & q.st[SB_RX_HOLDING_FULL];

endmodule : usf_top

`default_nettype wire

// ### bench/usf_monitor.sv
// usf_monitor: port assertions for usf_top, bound into every instance.
// assumes mclk, synchronous active-low rst_n and a one-wait Avalon slave.
`timescale 1ns/1ns
`default_nettype none
module usf_monitor #(
   parameter bit HAS_SYNC = 1'b1
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // pins and modes
   input wire logic tx_o,
   input wire logic tx_oe,
   input wire logic rx_valid,
   input wire logic rx_parity_err,
   input wire logic irda_enable,
   input wire logic dma_transmit_request,
   input wire logic dma_receive_request
);
   import usf_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic nack_q;
   logic hdx_q;
   sequence s_ctl;
      write && !waitrequest && address == OFS_CTRL && byteenable[0];
   endsequence
   sequence s_brk;
      write && !waitrequest && address == OFS_CTRL && writedata[CB_SBRK];
   endsequence
   // shadow of the control bits the pins depend on
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         nack_q <= 1'b0;
         hdx_q <= 1'b0;
      end else if (write && !waitrequest && address == OFS_CTRL && byteenable[0]) begin
         nack_q <= HAS_SYNC & writedata[CB_SC] & writedata[CB_NACK];
         hdx_q <= writedata[CB_HDX];
      end
   end
   chk_wait_once: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
      else $error("bus answer not after one wait cycle");
   chk_irda_follow: assert property (s_ctl |=> irda_enable == $past(writedata[CB_IRDA]))
      else $error("irda enable does not follow control write");
   chk_txe_drop: assert property (write && !waitrequest && address == OFS_DATA
      |=> !dma_transmit_request) else $error("transmit request after data write");
   chk_rx_holding_full_drop: assert property (read && !waitrequest && address == OFS_DATA && !rx_valid
      |=> !dma_receive_request) else $error("receive request after data read");
   chk_unmapped_zero: assert property (read && !waitrequest && address > OFS_PEND
      |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
   chk_nack_low: assert property (nack_q && rx_valid && rx_parity_err |-> ##[2:3] !tx_o)
      else $error("no nack after parity error");
   chk_break_low: assert property (s_brk |-> ##[2:4] !tx_o)
      else $error("break not driven low");
   chk_oe_full: assert property (!hdx_q |-> tx_oe)
      else $error("output enable low in full duplex");
endmodule : usf_monitor
bind usf_top usf_monitor #(.HAS_SYNC(HAS_SYNC)) mon (.mclk, .rst_n, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .tx_o, .tx_oe, .rx_valid, .rx_parity_err,
   .irda_enable, .dma_transmit_request, .dma_receive_request);
`default_nettype wire

// ### bench/usf_far_model.sv
// usf_far_model: baud tick and shift transmitter standing at the far side.
// assumes tx_load is a one-cycle pulse carrying a 9-bit character.
`timescale 1ns/1ns
`default_nettype none
module usf_far_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // shifter side
   input wire logic tx_load,
   input wire logic [8:0] tx_data,
   output logic tx_serial,
   output logic tx_done,
   output logic bit_tick,
   output logic [8:0] last_char
);
   logic [1:0] div;
   logic [10:0] sh;
   logic [3:0] left;
   assign bit_tick = (div == 2'h3);
   assign tx_serial = sh[0];
   always_ff @(posedge mclk) begin
      tx_done <= 1'b0;
      if (!rst_n) begin
         div <= 2'h0;
         sh <= 11'h7FF;
         left <= 4'h0;
      end else begin
         div <= div + 2'h1;
         if (tx_load) begin
            sh <= {1'b1, tx_data, 1'b0};
            left <= 4'hB;
            last_char <= tx_data;
         end else if (bit_tick && left != 4'h0) begin
            sh <= {1'b1, sh[10:1]};
            left <= left - 4'h1;
            tx_done <= (left == 4'h1);
         end
      end
   end
endmodule : usf_far_model
`default_nettype wire

// ### bench/usf_tb_top.sv
// usf_tb_top: self-checking bench for usf_top and the far-side model.
// assumes a 100 ns mclk and a one-wait Avalon slave.
`timescale 1ns/1ns
`default_nettype none
module usf_tb_top;
   import usf_pkg::*;
   typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} usf_row_t;
   logic mclk, rst_n, read, write, rx_i, tx_i, rx_valid, rx_idle, bit_tick, tx_serial, tx_done;
   logic rx_parity_err, rx_frame_err, rx_noise_err, waitrequest, tx_o, tx_oe, tx_load;
   logic irda_enable, irda_low_power, dma_transmit_request, dma_receive_request;
   logic cts_n, rx_line;
   logic [4:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, rd;
   logic [8:0] rx_data, tx_data, last_char;
   int mismatches, total_checks;
   usf_row_t rows[10];
   assign tx_i = tx_oe ? tx_o : 1'b1;
   usf_top uut (.mclk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .rx_i, .tx_i, .tx_o, .tx_oe, .cts_n, .bit_tick, .rx_line, .rx_valid,
      .rx_data, .rx_parity_err, .rx_frame_err, .rx_noise_err, .rx_idle, .tx_load, .tx_data,
      .tx_serial, .tx_done, .irda_enable, .irda_low_power, .dma_transmit_request,
      .dma_receive_request);
   usf_far_model far (.mclk, .rst_n, .tx_load, .tx_data, .tx_serial, .tx_done, .bit_tick,
      .last_char);
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      {read, write, address, writedata} <= {~w, w, a, d};
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         mismatches++;
         conclude();
      end
      rd = readdata;
      {read, write} <= 2'b00;
   endtask : bus
   task poll(input logic [4:0] a, input int b, input logic v);
      int n;
      n = 0;
      do begin
         bus(1'b0, a, 0);
         n++;
      end while (rd[b] !== v && n < 100);
      check("polled bit", rd[b], v);
      if (rd[b] !== v) conclude();
   endtask : poll
   task rxp(input logic [8:0] dt, input logic [3:0] f);
      @(posedge mclk);
      {rx_valid, rx_data, rx_idle, rx_noise_err, rx_frame_err, rx_parity_err} <= {1'b1, dt, f};
      @(posedge mclk);
      {rx_valid, rx_idle, rx_noise_err, rx_frame_err, rx_parity_err} <= 5'h00;
   endtask : rxp
   task reset;
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : reset
   initial begin
      {rst_n, read, write, rx_valid, rx_idle, rx_parity_err, rx_frame_err, rx_noise_err} = 8'h00;
      {cts_n, rx_i, address, writedata, rx_data, byteenable} = {2'b11, 5'h00, 32'h0, 9'h0, 4'hF};
      rows = '{'{0, OFS_STATUS, 0, ST_RST}, '{1, OFS_CTRL, 32'h0003_FFFB, 0},
         '{0, OFS_CTRL, 0, 32'h0003_FFFB}, '{0, OFS_PEND, 0, 32'h0000_00C0},
         '{1, OFS_PEND, 32'h0000_03FF, 0}, '{0, OFS_PEND, 0, 32'h0000_00C0},
         '{1, OFS_GUARD, 32'h0000_01A5, 0}, '{0, OFS_GUARD, 0, 32'h0000_00A5},
         '{0, 5'h14, 0, 0}, '{1, OFS_CTRL, 32'h0000_0300, 0}};
      reset();
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) check("row read", rd, rows[i].e);
      end
      @(negedge mclk);
      check("dma pair", {dma_transmit_request, dma_receive_request}, 2'b10);
      bus(1'b0, OFS_STATUS, 0);
      bus(1'b1, OFS_DATA, 32'h0000_01A5);
      bus(1'b0, OFS_STATUS, 0);
      check("tc after sequence", rd[SB_TC], 1'b0);
      poll(OFS_STATUS, SB_TC, 1'b1);
      check("sent char", last_char, 9'h1A5);
      rxp(9'h155, 4'hF);
      bus(1'b0, OFS_STATUS, 0);
      check("flags set", rd, 32'h0000_00F7);
      bus(1'b0, OFS_DATA, 0);
      check("data", rd, 32'h0000_0155);
      bus(1'b0, OFS_STATUS, 0);
      check("seq clear", rd, 32'h0000_00C0);
      bus(1'b0, OFS_DATA, 0);
      check("data again", rd, 32'h0000_0155);
      rxp(9'h0AA, 4'h7);
      rxp(9'h033, 4'h0);
      bus(1'b0, OFS_DATA, 0);
      check("kept data", rd, 32'h0000_00AA);
      bus(1'b0, OFS_STATUS, 0);
      check("data read only", rd, 32'h0000_00CF);
      bus(1'b1, OFS_STATUS, 0);
      bus(1'b0, OFS_STATUS, 0);
      check("status write", rd, 32'h0000_008F);
      cts_n <= 1'b0;
      repeat (8) @(posedge mclk);
      bus(1'b0, OFS_STATUS, 0);
      check("cts change", rd, 32'h0000_028F);
      bus(1'b1, OFS_STATUS, 32'h0000_01FF);
      bus(1'b0, OFS_STATUS, 0);
      check("cts cleared", rd, 32'h0000_008F);
      cts_n <= 1'b1;
      bus(1'b1, OFS_CTRL, 32'h0000_0004);
      poll(OFS_CTRL, CB_SBRK, 1'b0);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, OFS_STATUS, 32'h0000_02FF);
         bus(1'b1, OFS_CTRL, (i == 2) ? 0 : 1 + 2 * i);
         rx_i <= 1'b0;
         repeat ((8 + (i % 2)) * 4) @(posedge mclk);
         bus(1'b0, OFS_STATUS, 0);
         check("no early break", rd[SB_LBD], 1'b0);
         check("rx line", rx_line, 1'b0);
         repeat (16) @(posedge mclk);
         bus(1'b0, OFS_STATUS, 0);
         check("break flag", rd[SB_LBD], i != 2);
         rx_i <= 1'b1;
         repeat (8) @(posedge mclk);
      end
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, OFS_CTRL, k ? 32'h0000_0030 : 32'h0000_0010);
         rxp(9'h000, 4'h1);
         @(posedge mclk);
         @(negedge mclk);
         check("nack line", tx_o, !k);
      end
      bus(1'b1, OFS_CTRL, 32'h0000_00C8);
      @(negedge mclk);
      check("half duplex oe", tx_oe, 1'b0);
      check("irda pair", {irda_enable, irda_low_power}, 2'b11);
      reset();
      bus(1'b0, OFS_CTRL, 0);
      check("ctrl after reset", rd, 32'h0000_0000);
      bus(1'b0, OFS_STATUS, 0);
      check("status after reset", rd, ST_RST);
      conclude();
   end
endmodule : usf_tb_top
`default_nettype wire
